//--- hdl/bitrev_and_table_addressing.sv
// Operation
// - bit reversal only in X address generator and only for data writes
// - only modifier is bit reversed; pointers stay in normal order
// - active when pointer select not 1111, enable set, pre/post increment mode
// - enable flag is bit 15 of bit reverse control register
// - bits 14:0 hold pivot modifier, normally half buffer size
// - word data assumed; address bit 0 zero, modifier scaled to bytes
// - byte writes or other modes get normal addresses
// - active: pointer plus modifier with reverse carry, mode offset ignored, bit 0 cleared
// - bit reversal takes precedence over circular buffering on writes
// - 16 entry sequence equals mirrored 4-bit index
// - program words 24 bits, data words 16 bits, alignment kept
// - fetch and remapped program address bit 0 always zero
// - table address is page above 16-bit data effective address
// - page bit 7 clear selects user space, set selects configuration
// - table operations need no alignment; reads reach configuration space
// - word low read returns program bits 15:0
// - byte low read picks upper byte when select is 1, else lower
// - word high read returns bits 23:16 with upper data byte zero
// - byte high read with select 1 returns zero
// - program counter steps two per word; low and high share range
// - remapped program space is read only, low 16 bits exposed
`timescale 1ns/1ns
`include "bitrev_table_params.svh"
module bitrev_and_table_addressing
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out,
    input wire bitrev_table_pkg::agu_req_s agu_req_in,
    input wire logic [15:0] modulo_ea_in,
    input wire logic modulo_hit_in,
    output logic ea_valid_out,
    output logic [15:0] ea_out,
    output logic bitrev_used_out,
    input wire bitrev_table_pkg::table_req_s table_req_in,
    output logic [23:0] prog_addr_out,
    output logic prog_addr_valid_out,
    output logic prog_write_out,
    output logic prog_high_out,
    output logic config_space_out,
    input wire logic [23:0] prog_word_in,
    input wire logic prog_word_valid_in,
    output logic [15:0] table_rdata_out,
    output logic table_rdata_valid_out,
    input wire logic [22:0] pc_in,
    output logic [23:0] fetch_addr_out,
    input wire logic [15:0] psv_offset_in,
    input wire logic [7:0] psv_page_in,
    input wire logic psv_write_in,
    output logic [23:0] psv_addr_out,
    output logic psv_allow_out,
    output logic [15:0] psv_rdata_out
);
    import bitrev_table_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] bitrev_ctrl_r;
    logic [15:0] addr_mode_r;
    logic [7:0] table_page_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    wire logic wr_bitrev = reg_write_in && (reg_addr_in == `REG_BITREV_CTRL);
    wire logic wr_mode = reg_write_in && (reg_addr_in == `REG_ADDR_MODE);
    wire logic wr_page = reg_write_in && (reg_addr_in == `REG_TABLE_PAGE);

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            bitrev_ctrl_r <= `BITREV_CTRL_RST;
            addr_mode_r <= `ADDR_MODE_RST;
            table_page_r <= `TABLE_PAGE_RST;
            rdata_r <= 16'h0000;
        end
        else
        begin
            if (wr_bitrev)
                bitrev_ctrl_r <= reg_wdata_in;
            if (wr_mode)
                addr_mode_r <= reg_wdata_in;
            if (wr_page)
                table_page_r <= reg_wdata_in[7:0];
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // bit reversed write address
    // ----------------------------------------
    wire logic bitrev_enable = bitrev_ctrl_r[`BITREV_EN_BIT];
    wire logic [14:0] pivot = bitrev_ctrl_r[`BITREV_MOD_MSB:0];
    wire logic [3:0] bitrev_pointer_select = addr_mode_r[`PTR_SEL_MSB:`PTR_SEL_LSB];
    wire logic inc_mode = (agu_req_in.mode == AM_PRE_INC) ||
        (agu_req_in.mode == AM_POST_INC);
    // reads, byte writes and other modes fall through to normal addressing
    wire logic bitrev_active = agu_req_in.valid && agu_req_in.write &&
        !agu_req_in.byte_size && inc_mode && bitrev_enable &&
        (bitrev_pointer_select != `PTR_SEL_NONE) &&
        (agu_req_in.reg_num == bitrev_pointer_select);
    // word data: modifier scaled by two into a byte offset
    wire logic [15:0] mod_bytes = {pivot, 1'b0};
    // reverse carry add: reverse both, add normally, reverse back
    function automatic logic [15:0] mirror16(input logic [15:0] v);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 16; i++)
            m[i] = v[15 - i];
        return m;
    endfunction
    wire logic [15:0] rev_sum = mirror16(mirror16(agu_req_in.pointer) +
        mirror16(mod_bytes));
    wire logic [15:0] bitrev_ea = {rev_sum[15:1], 1'b0};
    wire logic [15:0] normal_base = modulo_hit_in ? modulo_ea_in : agu_req_in.pointer;
    wire logic [15:0] normal_ea = (agu_req_in.mode == AM_PRE_INC ||
        agu_req_in.mode == AM_PRE_DEC || agu_req_in.mode == AM_INDEXED) ?
        normal_base + agu_req_in.offset : normal_base;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ea_valid_out <= 1'b0;
            ea_out <= 16'h0000;
            bitrev_used_out <= 1'b0;
        end
        else
        begin
            ea_valid_out <= agu_req_in.valid;
            // held between requests so the last address stays readable
            if (agu_req_in.valid)
                ea_out <= bitrev_active ? bitrev_ea : normal_ea;
            bitrev_used_out <= bitrev_active;
        end
    end

    // ----------------------------------------
    // table address and data mapping
    // ----------------------------------------
    wire logic tbl_high = (table_req_in.op == TBL_READ_HIGH) ||
        (table_req_in.op == TBL_WRITE_HIGH);
    wire logic tbl_write = (table_req_in.op == TBL_WRITE_LOW) ||
        (table_req_in.op == TBL_WRITE_HIGH);
    // no alignment check on the ea; low and high share one range
    wire logic [23:0] tbl_addr = {table_page_r, table_req_in.ea};
    logic byte_sel_r;
    logic byte_mode_r;
    logic high_r;
    logic pending_r;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            prog_addr_out <= 24'h000000;
            prog_addr_valid_out <= 1'b0;
            prog_write_out <= 1'b0;
            prog_high_out <= 1'b0;
            config_space_out <= 1'b0;
            byte_sel_r <= 1'b0;
            byte_mode_r <= 1'b0;
            high_r <= 1'b0;
            pending_r <= 1'b0;
        end
        else
        begin
            prog_addr_valid_out <= table_req_in.valid;
            if (table_req_in.valid)
            begin
                prog_addr_out <= tbl_addr;
                prog_write_out <= tbl_write;
                prog_high_out <= tbl_high;
                config_space_out <= table_page_r[`TABLE_CFG_BIT];
                byte_sel_r <= table_req_in.ea[0];
                byte_mode_r <= table_req_in.byte_mode;
                high_r <= tbl_high;
                pending_r <= !tbl_write;
            end
            else if (prog_word_valid_in)
                pending_r <= 1'b0;
        end
    end

    logic [15:0] tbl_data;
    always_comb
    begin
        if (!high_r)
            tbl_data = !byte_mode_r ? prog_word_in[15:0] :
                (byte_sel_r ? {8'h00, prog_word_in[15:8]} :
                {8'h00, prog_word_in[7:0]});
        else
            tbl_data = (byte_mode_r && byte_sel_r) ? 16'h0000 :
                {8'h00, prog_word_in[23:16]};
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            table_rdata_out <= 16'h0000;
            table_rdata_valid_out <= 1'b0;
        end
        else
        begin
            table_rdata_valid_out <= pending_r && prog_word_valid_in;
            if (pending_r && prog_word_valid_in)
                table_rdata_out <= tbl_data;
        end
    end

    // ----------------------------------------
    // fetch and program space visibility
    // ----------------------------------------
    assign fetch_addr_out = {pc_in, 1'b0};
    assign psv_addr_out = {psv_page_in, psv_offset_in[15:1], 1'b0};
    assign psv_allow_out = !psv_write_in;
    assign psv_rdata_out = prog_word_in[15:0];

    // ----------------------------------------
    // register readback
    // ----------------------------------------
    always_comb
    begin
        unique case (reg_addr_in)
            `REG_BITREV_CTRL: rdata_nxt = bitrev_ctrl_r;
            `REG_ADDR_MODE: rdata_nxt = addr_mode_r;
            `REG_TABLE_PAGE: rdata_nxt = {8'h00, table_page_r};
            `REG_LAST_EA: rdata_nxt = ea_out;
            `REG_LAST_PADDR_LO: rdata_nxt = prog_addr_out[15:0];
            `REG_LAST_PADDR_HI: rdata_nxt = {8'h00, prog_addr_out[23:16]};
            default: rdata_nxt = 16'h0000;
        endcase
        if (!reg_read_in)
            rdata_nxt = 16'h0000;
    end
    assign reg_rdata_out = rdata_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // byte lanes of the returning word, named for the data checks
    wire logic [7:0] word_upper = prog_word_in[23:16];
    wire logic [7:0] word_middle = prog_word_in[15:8];
    wire logic [7:0] word_lower = prog_word_in[7:0];

    sequence bitrev_write_req;
        agu_req_in.valid && agu_req_in.write && !agu_req_in.byte_size && inc_mode;
    endsequence
    sequence bitrev_armed;
        bitrev_enable && (bitrev_pointer_select != `PTR_SEL_NONE) &&
            (agu_req_in.reg_num == bitrev_pointer_select);
    endsequence
    sequence table_read_issued;
        table_req_in.valid && !tbl_write;
    endsequence
    sequence table_word_back;
        pending_r && prog_word_valid_in;
    endsequence
    sequence low_byte_back;
        table_word_back ##0 (!high_r && byte_mode_r);
    endsequence

    chk_bitrev_read_off: assert property (@(posedge clk_in) disable iff (rst_in)
        agu_req_in.valid && !agu_req_in.write |=> !bitrev_used_out)
        else $error("bit reversal on a read");
    chk_bitrev_lsb: assert property (@(posedge clk_in) disable iff (rst_in)
        bitrev_used_out |-> ea_out[0] == 1'b0)
        else $error("bit reversed address odd");
    chk_bitrev_cond: assert property (@(posedge clk_in) disable iff (rst_in)
        bitrev_used_out |-> $past(bitrev_enable) && $past(inc_mode) &&
            ($past(bitrev_pointer_select) != `PTR_SEL_NONE))
        else $error("bit reversal without enable");
    chk_byte_normal: assert property (@(posedge clk_in) disable iff (rst_in)
        agu_req_in.valid && agu_req_in.byte_size |=> !bitrev_used_out)
        else $error("bit reversal on byte write");
    chk_table_addr: assert property (@(posedge clk_in) disable iff (rst_in)
        table_req_in.valid |=>
            prog_addr_out == {$past(table_page_r), $past(table_req_in.ea)})
        else $error("table address wrong");
    chk_cfg_space: assert property (@(posedge clk_in) disable iff (rst_in)
        prog_addr_valid_out |-> config_space_out == prog_addr_out[23])
        else $error("config space flag wrong");
    chk_high_phantom: assert property (@(posedge clk_in) disable iff (rst_in)
        table_rdata_valid_out && $past(high_r) |-> table_rdata_out[15:8] == 8'h00)
        else $error("phantom byte not zero");
    chk_fetch_even: assert property (@(posedge clk_in) disable iff (rst_in)
        fetch_addr_out[0] == 1'b0 && psv_addr_out[0] == 1'b0)
        else $error("program address odd");
    chk_psv_ro: assert property (@(posedge clk_in) disable iff (rst_in)
        psv_write_in |-> !psv_allow_out)
        else $error("write allowed into remapped space");
    chk_mode_normal: assert property (@(posedge clk_in) disable iff (rst_in)
        agu_req_in.valid && !inc_mode |=> !bitrev_used_out)
        else $error("bit reversal outside increment modes");
    chk_disabled_normal: assert property (@(posedge clk_in) disable iff (rst_in)
        agu_req_in.valid && !bitrev_enable |=> !bitrev_used_out)
        else $error("bit reversal while disabled");
    chk_bitrev_taken: assert property (@(posedge clk_in) disable iff (rst_in)
        bitrev_write_req ##0 bitrev_armed |=> bitrev_used_out && ea_valid_out)
        else $error("bit reversal not applied");
    chk_table_issue: assert property (@(posedge clk_in) disable iff (rst_in)
        table_read_issued |=> prog_addr_valid_out && !prog_write_out && pending_r)
        else $error("table read not issued");
    chk_table_return: assert property (@(posedge clk_in) disable iff (rst_in)
        table_word_back |=> table_rdata_valid_out)
        else $error("table data not returned");
    chk_low_word: assert property (@(posedge clk_in) disable iff (rst_in)
        table_word_back ##0 (!high_r && !byte_mode_r) |=>
            table_rdata_out == {$past(word_middle), $past(word_lower)})
        else $error("low word read wrong");
    chk_low_byte_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        low_byte_back ##0 byte_sel_r |=> table_rdata_out[7:0] == $past(word_middle))
        else $error("upper byte of low word not picked");
    chk_low_byte_clr: assert property (@(posedge clk_in) disable iff (rst_in)
        low_byte_back ##0 !byte_sel_r |=> table_rdata_out[7:0] == $past(word_lower))
        else $error("lower byte of low word not picked");
    chk_high_word: assert property (@(posedge clk_in) disable iff (rst_in)
        table_word_back ##0 (high_r && !(byte_mode_r && byte_sel_r)) |=>
            table_rdata_out == {8'h00, $past(word_upper)})
        else $error("high word read wrong");
    chk_phantom_byte: assert property (@(posedge clk_in) disable iff (rst_in)
        table_word_back ##0 (high_r && byte_mode_r && byte_sel_r) |=>
            table_rdata_out == 16'h0000)
        else $error("phantom byte read not zero");
    chk_page_space: assert property (@(posedge clk_in) disable iff (rst_in)
        table_req_in.valid && !table_page_r[`TABLE_CFG_BIT] |=> !config_space_out)
        else $error("user page flagged as config space");
    chk_ea_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
        agu_req_in.valid |=> ea_valid_out)
        else $error("address request not answered");
    chk_ea_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !agu_req_in.valid |=> $stable(ea_out))
        else $error("address changed without a request");
    chk_rdata_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        !reg_read_in |=> reg_rdata_out == 16'h0000)
        else $error("read data without a read");
endmodule

//--- hdl/bitrev_table_params.svh
`ifndef BITREV_TABLE_PARAMS_SVH
`define BITREV_TABLE_PARAMS_SVH
// register map (word index on the plain register port)
`define REG_BITREV_CTRL 4'h0
`define REG_ADDR_MODE 4'h1
`define REG_TABLE_PAGE 4'h2
`define REG_LAST_EA 4'h3
`define REG_LAST_PADDR_LO 4'h4
`define REG_LAST_PADDR_HI 4'h5
// field positions
`define BITREV_EN_BIT 15
`define BITREV_MOD_MSB 14
`define PTR_SEL_MSB 11
`define PTR_SEL_LSB 8
`define TABLE_CFG_BIT 7
// reset values and codes
`define BITREV_CTRL_RST 16'h0000
`define ADDR_MODE_RST 16'h0f00
`define TABLE_PAGE_RST 8'h00
`define PTR_SEL_NONE 4'hf
`endif

//--- hdl/bitrev_table_pkg.sv
package bitrev_table_pkg;
    typedef enum logic [2:0]
    {
        AM_DIRECT,
        AM_INDIRECT,
        AM_POST_INC,
        AM_POST_DEC,
        AM_PRE_INC,
        AM_PRE_DEC,
        AM_INDEXED
    } addr_mode_e;

    typedef enum logic [1:0]
    {
        TBL_READ_LOW,
        TBL_READ_HIGH,
        TBL_WRITE_LOW,
        TBL_WRITE_HIGH
    } table_op_e;

    typedef struct packed
    {
        logic valid;
        logic write;
        logic byte_size;
        addr_mode_e mode;
        logic [3:0] reg_num;
        logic [15:0] pointer;
        logic [15:0] offset;
    } agu_req_s;

    typedef struct packed
    {
        logic valid;
        table_op_e op;
        logic byte_mode;
        logic [15:0] ea;
    } table_req_s;
endpackage

//--- tb/prog_mem_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// program memory behind the table port
// ----------------------------------------
module prog_mem_model
(
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic [23:0] addr_in,
    input wire logic addr_valid_in,
    input wire logic write_in,
    output logic [23:0] word_out,
    output logic word_valid_out
);
    logic [1:0] wait_r = 2'h0;
    logic [23:0] idle_r = 24'h5a5a5a;
    logic fast;
    // contents hang on the word address only, bit 0 never selects a word
    function automatic logic [23:0] word_at(input logic [23:0] a);
        return {a[8:1] ^ 8'h5a, a[16:9] ^ 8'h3c, a[8:1]};
    endfunction
    assign fast = addr_valid_in && !write_in && !slow_in;
    always_ff @(posedge clk_in)
    begin
        idle_r <= ~idle_r;
        if (addr_valid_in && !write_in && slow_in)
            wait_r <= 2'h2;
        else if (wait_r != 2'h0)
            wait_r <= wait_r - 2'h1;
    end
    assign word_valid_out = fast || wait_r == 2'h1;
    // an idle bus toggles so a stale word can never look right
    assign word_out = word_valid_out ? word_at(addr_in) : idle_r;
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ns
`include "bitrev_table_params.svh"
module testbench;
    import bitrev_table_pkg::*;
    typedef struct packed
    {
        logic w;
        logic b;
        addr_mode_e m;
        logic [3:0] r;
        logic [15:0] p;
        logic [15:0] o;
        logic h;
        logic [15:0] e;
        logic u;
    } row_s;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, mod_hit = 1'b0, slow = 1'b0, psv_wr = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, psv_off = 16'h4567, reg_rdata, ea, tdata, psv_rdata;
    logic [7:0] psv_page = 8'h12;
    logic [22:0] pc = 23'h123457;
    logic [23:0] paddr, pword, fetch, psv_addr;
    logic ea_valid, br_used, paddr_valid, pwrite, phigh, pcfg, pword_valid, tdata_valid, psv_allow;
    agu_req_s agu_req = '0;
    table_req_s tbl_req = '0;
    int n_errors = 0;
    int n_compared = 0;
    int i;
    logic [15:0] p;
    row_s rows [13] = '{
        '{1'b1, 1'b0, AM_POST_INC, 4'h8, 16'h2000, 16'h0002, 1'b0, 16'h2010, 1'b1},
        '{1'b1, 1'b0, AM_PRE_INC, 4'h8, 16'h2010, 16'h0002, 1'b0, 16'h2008, 1'b1},
        '{1'b0, 1'b0, AM_PRE_INC, 4'h8, 16'h2000, 16'h0002, 1'b0, 16'h2002, 1'b0},
        '{1'b1, 1'b1, AM_POST_INC, 4'h8, 16'h2000, 16'h0001, 1'b0, 16'h2000, 1'b0},
        '{1'b1, 1'b0, AM_PRE_DEC, 4'h8, 16'h2000, 16'hfffe, 1'b0, 16'h1ffe, 1'b0},
        '{1'b1, 1'b0, AM_INDEXED, 4'h8, 16'h2000, 16'h0004, 1'b0, 16'h2004, 1'b0},
        '{1'b1, 1'b0, AM_POST_INC, 4'h7, 16'h2000, 16'h0002, 1'b0, 16'h2000, 1'b0},
        '{1'b1, 1'b0, AM_PRE_INC, 4'h8, 16'h2000, 16'h0002, 1'b1, 16'h2010, 1'b1},
        '{1'b0, 1'b0, AM_POST_INC, 4'h8, 16'h2000, 16'h0002, 1'b1, 16'h3000, 1'b0},
        '{1'b1, 1'b0, AM_POST_INC, 4'h8, 16'h2001, 16'h0002, 1'b0, 16'h2010, 1'b1},
        '{1'b1, 1'b0, AM_DIRECT, 4'h8, 16'h0040, 16'h0002, 1'b0, 16'h0040, 1'b0},
        '{1'b1, 1'b0, AM_INDIRECT, 4'h8, 16'h0040, 16'h0002, 1'b0, 16'h0040, 1'b0},
        '{1'b1, 1'b0, AM_POST_DEC, 4'h8, 16'h0040, 16'hfffe, 1'b0, 16'h0040, 1'b0}};

    bitrev_and_table_addressing dut_u
    (
        .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_write_in(reg_wr), .reg_read_in(reg_rd), .reg_rdata_out(reg_rdata),
        .agu_req_in(agu_req), .modulo_ea_in(16'h3000), .modulo_hit_in(mod_hit),
        .ea_valid_out(ea_valid), .ea_out(ea), .bitrev_used_out(br_used),
        .table_req_in(tbl_req), .prog_addr_out(paddr), .prog_addr_valid_out(paddr_valid),
        .prog_write_out(pwrite), .prog_high_out(phigh), .config_space_out(pcfg),
        .prog_word_in(pword), .prog_word_valid_in(pword_valid), .table_rdata_out(tdata),
        .table_rdata_valid_out(tdata_valid), .pc_in(pc), .fetch_addr_out(fetch),
        .psv_offset_in(psv_off), .psv_page_in(psv_page), .psv_write_in(psv_wr),
        .psv_addr_out(psv_addr), .psv_allow_out(psv_allow), .psv_rdata_out(psv_rdata)
    );
    prog_mem_model mem_u
    (
        .clk_in(clk_in), .slow_in(slow), .addr_in(paddr), .addr_valid_in(paddr_valid),
        .write_in(pwrite), .word_out(pword), .word_valid_out(pword_valid)
    );

    function automatic logic [23:0] word_at(input logic [23:0] a);
        return {a[8:1] ^ 8'h5a, a[16:9] ^ 8'h3c, a[8:1]};
    endfunction
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask
    task automatic address_generator(input row_s t);
        @(posedge clk_in);
        agu_req <= '{1'b1, t.w, t.b, t.m, t.r, t.p, t.o};
        mod_hit <= t.h;
        @(posedge clk_in);
        agu_req.valid <= 1'b0;
        #1 chk("ea_valid", 1'b1, ea_valid);
        chk("ea", t.e, ea);
        chk("bitrev_used", t.u, br_used);
    endtask
    task automatic tbl(input logic [1:0] op, input logic bm, input logic [15:0] a, input logic [7:0] pg);
        logic [23:0] w;
        logic [15:0] e;
        logic [15:0] m;
        int k;
        @(posedge clk_in);
        tbl_req <= '{1'b1, table_op_e'(op), bm, a};
        @(posedge clk_in);
        tbl_req.valid <= 1'b0;
        #1 chk("prog_addr_valid", 1'b1, paddr_valid);
        chk("prog_addr", {pg, a[15:1]}, paddr[23:1]);
        chk("prog_high", op[0], phigh);
        chk("prog_write", op[1], pwrite);
        chk("config_space", pg[7], pcfg);
        if (op[1])
            return;
        w = word_at({pg, a[15:1], 1'b0});
        e = op[0] ? (bm && a[0] ? 16'h0000 : {8'h00, w[23:16]})
                  : (bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w[15:0]);
        m = bm ? 16'h00ff : 16'hffff;
        k = 0;
        while (tdata_valid !== 1'b1 && k < 8)
        begin
            @(posedge clk_in);
            #1 k++;
        end
        chk("table_rdata", e & m, tdata & m);
    endtask
    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog and test sequence
    // ----------------------------------------
    initial
    begin
        forever #10 clk_in = ~clk_in;
    end
    initial
    begin
        repeat (5000) @(posedge clk_in);
        n_errors++;
        stop_test;
    end
    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(`REG_BITREV_CTRL, `BITREV_CTRL_RST);
        rd(`REG_ADDR_MODE, `ADDR_MODE_RST);
        rd(`REG_TABLE_PAGE, {8'h00, `TABLE_PAGE_RST});
        wr(`REG_ADDR_MODE, 16'h0800);
        // the control write is read straight back before the address rows run
        wr(`REG_BITREV_CTRL, 16'h8008);
        rd(`REG_BITREV_CTRL, 16'h8008);
        for (i = 0; i < 13; i++)
            address_generator(rows[i]);
        // start at the last entry of the aligned buffer so the first step wraps onto its start
        p = 16'h101e;
        for (i = 0; i < 16; i++)
        begin
            address_generator('{1'b1, 1'b0, AM_POST_INC, 4'h8, p, 16'h0002, 1'b0,
                16'h1000 + {11'h000, {i[0], i[1], i[2], i[3]} + 4'h0, 1'b0}, 1'b1});
            p = 16'h1000 + {11'h000, {i[0], i[1], i[2], i[3]}, 1'b0};
        end
        wr(4'h9, 16'hffff);
        rd(4'h9, 16'h0000);
        wr(`REG_BITREV_CTRL, 16'h0008);
        address_generator('{1'b1, 1'b0, AM_POST_INC, 4'h8, 16'h2000, 16'h0002, 1'b0, 16'h2000, 1'b0});
        wr(`REG_BITREV_CTRL, 16'h8008);
        wr(`REG_ADDR_MODE, 16'h0f00);
        address_generator('{1'b1, 1'b0, AM_POST_INC, 4'hf, 16'h2000, 16'h0002, 1'b0, 16'h2000, 1'b0});
        rd(`REG_LAST_EA, 16'h2000);
        wr(`REG_TABLE_PAGE, 16'h0005);
        for (i = 0; i < 16; i++)
        begin
            if (i == 8)
                wr(`REG_TABLE_PAGE, 16'h0081);
            slow <= i[1];
            tbl(i[3:2], i[1], 16'h1234 | i[0], i < 8 ? 8'h05 : 8'h81);
        end
        tbl(2'h1, 1'b0, 16'h8abc, 8'h81);
        rd(`REG_LAST_PADDR_LO, 16'h8abc);
        rd(`REG_LAST_PADDR_HI, 16'h0081);
        #1 chk("fetch_addr", {pc, 1'b0}, fetch);
        chk("psv_addr", {psv_page, psv_off[15:1], 1'b0}, psv_addr);
        chk("psv_allow", 1'b1, psv_allow);
        chk("psv_rdata", pword[15:0], psv_rdata);
        @(posedge clk_in);
        psv_wr <= 1'b1;
        #1 chk("psv_allow", 1'b0, psv_allow);
        @(posedge clk_in);
        rst_in <= 1'b1;
        @(posedge clk_in);
        rst_in <= 1'b0;
        #1 chk("prog_addr", 24'h000000, paddr);
        chk("ea_valid", 1'b0, ea_valid);
        rd(`REG_BITREV_CTRL, `BITREV_CTRL_RST);
        rd(`REG_ADDR_MODE, `ADDR_MODE_RST);
        rd(`REG_LAST_EA, 16'h0000);
        stop_test;
    end
endmodule
